// [hdl/mcu_reset_controller.sv]
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "rstctl_params.svh"
module mcu_reset_controller
	import rstctl_pkg::*;
(
	// clock and power-on reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pin and supply monitor
	input  wire logic        reset_pin_in,
	input  wire logic        supply_below_threshold,
	input  wire logic        slow_tick,
	input  wire logic        low_power_mode,
	input  wire logic        watchdog_cfg_fault,
	// to the core
	output logic             core_reset,
	output logic             pc_clear,
	output logic             port_preset,
	output logic             reset_pin_selected,
	output logic [2:0]       threshold_level
);

	// register contents
	logic [7:0]  reset_pin_mode;
	logic [3:0]  reset_source_flags;
	logic [7:0]  low_voltage_threshold;
	logic [1:0]  filter_time_select;

	// synchronisers and low-voltage filter
	logic [2:0]  pin_sync;
	logic [2:0]  supply_sync;
	logic        pin_level;
	logic        supply_low;
	logic [7:0]  filter_count;
	logic [7:0]  filter_limit;

	// software-reset delay counters
	logic [15:0] pin_delay;
	logic [15:0] thr_delay;
	logic        pin_pending;
	logic        thr_pending;

	// reset sequencer
	logic [15:0] release_count;
	logic [7:0]  pulse_count;
	logic        por_done;
	logic        pin_hold;
	rst_state_t  state;
	rst_cause_t  cause;

	// decoded conditions
	logic        pin_mode_bad;
	logic        thr_bad;
	logic        lv_enable;
	logic        lv_trip;
	logic        wr_en;
	logic        pin_reset_req;
	logic [3:0]  flag_clear;

	assign wr_en = psel && penable && pwrite;

	// code checks on the guarded registers
	assign pin_mode_bad = (reset_pin_mode != `PIN_MODE_IO) &&
		(reset_pin_mode != `PIN_MODE_RESET);
	always_comb begin
		case (low_voltage_threshold)
		`THR_1V7, `THR_1V9, `THR_2V55, `THR_3V15, `THR_3V8,
		`THR_DISABLE: thr_bad = 1'b0;
		default: thr_bad = 1'b1;
		endcase
	end
	assign lv_enable = (low_voltage_threshold != `THR_DISABLE) &&
		!thr_bad && !low_power_mode;
	assign pin_reset_req = (reset_pin_mode == `PIN_MODE_RESET) &&
		!pin_level;

	// filtered low-voltage condition that asks for a reset
	assign lv_trip = lv_enable &&
		(filter_count == filter_limit);

	// software clear mask, a zero written to a flag bit clears it
	always_comb begin
		flag_clear = 4'h0;
		if (wr_en && paddr == `OFF_FLAGS)
			flag_clear = ~pwdata[3:0];
	end

	// filter length per select code
	always_comb begin
		case (filter_time_select)
		2'h0: filter_limit = 8'h08;
		2'h1: filter_limit = 8'h20;
		2'h2: filter_limit = 8'h40;
		default: filter_limit = 8'h80;
		endcase
	end

	// pin and supply synchronisers, change counts once stages 2 and 3 agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync <= 3'h7;
			supply_sync <= 3'h0;
			pin_level <= 1'b1;
			supply_low <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], reset_pin_in};
			supply_sync <= {supply_sync[1:0], supply_below_threshold};
			if (pin_sync[2] == pin_sync[1])
				pin_level <= pin_sync[2];
			if (supply_sync[2] == supply_sync[1])
				supply_low <= supply_sync[2];
		end
	end

	// low-voltage duration filter in slow-clock ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_count <= 8'h00;
		end else if (!supply_low || !lv_enable || state != st_run) begin
			filter_count <= 8'h00;
		end else if (slow_tick && filter_count != filter_limit) begin
			filter_count <= filter_count + 8'h01;
		end
	end

	// software-reset delay counters, one request per detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_delay <= 16'h0000;
			thr_delay <= 16'h0000;
			pin_pending <= 1'b0;
			thr_pending <= 1'b0;
		end else begin
			pin_pending <= 1'b0;
			thr_pending <= 1'b0;
			if (!pin_mode_bad || state != st_run)
				pin_delay <= 16'h0000;
			else if (pin_delay != `SRESET_CYCLES) begin
				pin_delay <= pin_delay + 16'h0001;
				if (pin_delay == `SRESET_CYCLES - 16'h0001)
					pin_pending <= 1'b1;
			end
			if (!thr_bad || state != st_run)
				thr_delay <= 16'h0000;
			else if (thr_delay != `SRESET_CYCLES) begin
				thr_delay <= thr_delay + 16'h0001;
				if (thr_delay == `SRESET_CYCLES - 16'h0001)
					thr_pending <= 1'b1;
			end
		end
	end

	// remembers a pin reset until the pin is seen high again, since the
	// pin mode register itself returns to its power-on value in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_hold <= 1'b0;
		else if (pin_reset_req)
			pin_hold <= 1'b1;
		else if (pin_level)
			pin_hold <= 1'b0;
	end

	// reset sequencer: pulse, then hold until release delay counted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_reset;
			cause <= '0;
			pulse_count <= 8'h00;
			release_count <= 16'h0000;
			por_done <= 1'b0;
		end else begin
			case (state)
			st_run: begin
				cause <= '0;
				pulse_count <= 8'h00;
				if (pin_reset_req) begin
					state <= st_reset;
					// a threshold fault maturing now keeps its flag
					cause.threshold_fault <= thr_pending;
				end else if (pin_pending || thr_pending ||
					lv_trip) begin
					state <= st_reset;
					cause.pin_mode_fault <= pin_pending;
					cause.threshold_fault <= thr_pending;
					cause.low_voltage <= !pin_pending && !thr_pending;
				end
			end
			st_reset: begin
				cause <= '0;
				release_count <= 16'h0000;
				if (pulse_count != `RESET_PULSE)
					pulse_count <= pulse_count + 8'h01;
				else if (!pin_reset_req && !pin_hold) begin
					state <= st_release;
					por_done <= 1'b1;
				end
			end
			st_release: begin
				if (pin_reset_req)
					state <= st_reset;
				else if (release_count == `RELEASE_TICKS)
					state <= st_run;
				else if (slow_tick)
					release_count <= release_count + 16'h0001;
			end
			default: state <= st_reset;
			endcase
		end
	end

	// pin mode register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_pin_mode <= `PIN_MODE_IO;
		end else if (state == st_reset) begin
			reset_pin_mode <= `PIN_MODE_IO;
		end else if (wr_en && paddr == `OFF_PIN_MODE) begin
			reset_pin_mode <= pwdata[7:0];
		end
	end

	// threshold register, kept across a genuine low-voltage reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_voltage_threshold <= `THR_1V7;
		end else if (state == st_run && thr_pending) begin
			low_voltage_threshold <= `THR_1V7;
		end else if (wr_en && paddr == `OFF_THRESHOLD) begin
			low_voltage_threshold <= pwdata[7:0];
		end
	end

	// filter time select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			filter_time_select <= `FILTER_RESET;
		else if (wr_en && paddr == `OFF_FILTER)
			filter_time_select <= pwdata[1:0];
	end

	// sticky flags: set wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_source_flags <= 4'h0;
		end else begin
			// clear first, so a set in the same cycle wins
			reset_source_flags <= reset_source_flags & ~flag_clear;
			if (cause.pin_mode_fault)
				reset_source_flags[`FLG_PIN_MODE] <= 1'b1;
			if (cause.low_voltage)
				reset_source_flags[`FLG_LOW_VOLT] <= 1'b1;
			if (cause.threshold_fault)
				reset_source_flags[`FLG_THRESHOLD] <= 1'b1;
			if (watchdog_cfg_fault)
				reset_source_flags[`FLG_WATCHDOG] <= 1'b1;
		end
	end

	// apb read data and handshake, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable) begin
				case (paddr)
				`OFF_PIN_MODE: prdata <= {24'h000000, reset_pin_mode};
				`OFF_FLAGS: prdata <= {28'h0000000,
					reset_source_flags};
				`OFF_THRESHOLD:
					prdata <= {24'h000000, low_voltage_threshold};
				`OFF_FILTER: prdata <= {30'h00000000, filter_time_select};
				`OFF_CONTROL: prdata <= {29'h00000000, state == st_run,
					supply_low, reset_pin_selected};
				default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// outputs toward core and pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset <= 1'b1;
			pc_clear <= 1'b1;
			port_preset <= 1'b1;
			reset_pin_selected <= 1'b0;
			threshold_level <= 3'h0;
		end else begin
			core_reset <= state != st_run;
			pc_clear <= state != st_run;
			port_preset <= !por_done;
			reset_pin_selected <=
				reset_pin_mode == `PIN_MODE_RESET;
			case (low_voltage_threshold)
			`THR_1V9: threshold_level <= 3'h1;
			`THR_2V55: threshold_level <= 3'h2;
			`THR_3V15: threshold_level <= 3'h3;
			`THR_3V8: threshold_level <= 3'h4;
			`THR_DISABLE: threshold_level <= 3'h7;
			default: threshold_level <= 3'h0;
			endcase
		end
	end

endmodule

// [hdl/rstctl_params.svh]
`ifndef RSTCTL_PARAMS_SVH
`define RSTCTL_PARAMS_SVH
// register byte addresses on the APB
`define OFF_PIN_MODE     12'h000
`define OFF_FLAGS        12'h004
`define OFF_THRESHOLD    12'h008
`define OFF_FILTER       12'h00C
`define OFF_CONTROL      12'h010
// codes and reset values
`define PIN_MODE_IO      8'h55
`define PIN_MODE_RESET   8'hAA
`define THR_1V7          8'h66
`define THR_1V9          8'h55
`define THR_2V55         8'h33
`define THR_3V15         8'h99
`define THR_3V8          8'hAA
`define THR_DISABLE      8'hF0
`define FILTER_RESET     2'h1
// flag bit positions
`define FLG_PIN_MODE     3
`define FLG_LOW_VOLT     2
`define FLG_THRESHOLD    1
`define FLG_WATCHDOG     0
// software-reset delay in pclk cycles, release delay in slow ticks
`define SRESET_CYCLES    16'h0010
`define RELEASE_TICKS    16'h0010
// reset pulse length in pclk cycles
`define RESET_PULSE      8'h04
`endif

// [hdl/rstctl_pkg.sv]
package rstctl_pkg;
	typedef enum logic [1:0] {
		st_run     = 2'b00,
		st_reset   = 2'b01,
		st_release = 2'b10
	} rst_state_t;
	typedef struct packed {
		logic       pin_mode_fault;
		logic       low_voltage;
		logic       threshold_fault;
	} rst_cause_t;
endpackage

// [dv/rstctl_sva.sv]
`timescale 1ns/1ps
`include "rstctl_params.svh"
module rstctl_sva (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pin and supply side
	input wire logic        reset_pin_in,
	input wire logic        supply_below_threshold,
	input wire logic        slow_tick,
	input wire logic        low_power_mode,
	input wire logic        watchdog_cfg_fault,
	// core side
	input wire logic        core_reset,
	input wire logic        pc_clear,
	input wire logic        port_preset,
	input wire logic        reset_pin_selected,
	input wire logic [2:0]  threshold_level
);
	logic [7:0] tick_cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// slow ticks seen while the core is held in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_cnt <= 8'h00;
		else if (!core_reset)
			tick_cnt <= 8'h00;
		else if (slow_tick && tick_cnt != 8'hFF)
			tick_cnt <= tick_cnt + 8'h01;
	end
	sequence s_wr(a);
		psel && penable && pready && pwrite && paddr == a && !core_reset;
	endsequence
	sequence s_pin_low;
		(reset_pin_selected && !reset_pin_in)[*4];
	endsequence
	a_pc_follows: assert property (pc_clear == core_reset)
		else $error("pc_clear differs from core_reset");
	a_preset_in_reset: assert property (port_preset |-> core_reset)
		else $error("port preset outside reset");
	a_pin_reset: assert property (s_pin_low |-> ##[0:3] core_reset)
		else $error("low reset pin ignored");
	a_pin_select: assert property (s_wr(`OFF_PIN_MODE) ##0
		pwdata[7:0] == `PIN_MODE_RESET |-> ##[1:2] reset_pin_selected)
		else $error("reset pin not selected");
	a_thr_disable: assert property (s_wr(`OFF_THRESHOLD) ##0
		pwdata[7:0] == `THR_DISABLE |-> ##[1:2] threshold_level == 3'h7)
		else $error("threshold disable not decoded");
	a_flags_upper: assert property (psel && penable && pready && !pwrite
		&& paddr == `OFF_FLAGS |-> prdata[31:4] == 28'h0)
		else $error("upper flag bits not zero");
	a_fault_delay: assert property (s_wr(`OFF_PIN_MODE) ##0
		pwdata[7:0] != `PIN_MODE_IO && pwdata[7:0] != `PIN_MODE_RESET
		|=> !core_reset[*8] ##[4:14] core_reset)
		else $error("bad pin mode reset timing");
	a_release_wait: assert property ($fell(core_reset)
		|-> {8'h00, $past(tick_cnt)} >= `RELEASE_TICKS)
		else $error("reset released too early");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
endmodule

// [dv/supply_pin_model.sv]
`timescale 1ns/1ps
module supply_pin_model (
	// clock and power-on reset
	input  wire logic pclk,
	input  wire logic presetn,
	// requests from the bench
	input  wire logic pin_pull_low,
	input  wire logic supply_sag,
	// pin, supply monitor and slow clock
	output logic      reset_pin_in,
	output logic      supply_below_threshold,
	output logic      slow_tick
);
	logic [1:0] div;
	// slow clock runs free at a quarter of pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div <= 2'h0;
		else
			div <= div + 2'h1;
	end
	assign slow_tick = (div == 2'h3);
	// pull-up keeps the pin high unless the network pulls it low
	assign reset_pin_in = !pin_pull_low;
	assign supply_below_threshold = supply_sag;
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "rstctl_params.svh"
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v, exp_q[$];
	logic        reset_pin_in, supply_below_threshold, slow_tick;
	logic        low_power_mode, watchdog_cfg_fault, pin_low, sag;
	logic        core_reset, pc_clear, port_preset, reset_pin_selected;
	logic [2:0]  threshold_level;
	logic [7:0]  codes[6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
	logic [2:0]  lvls[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	int          checks, bad_count, seed;
	mcu_reset_controller u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_in,
		.supply_below_threshold, .slow_tick, .low_power_mode,
		.watchdog_cfg_fault, .core_reset, .pc_clear, .port_preset,
		.reset_pin_selected, .threshold_level);
	supply_pin_model u_far (.pclk, .presetn, .pin_pull_low(pin_low),
		.supply_sag(sag), .reset_pin_in, .supply_below_threshold, .slow_tick);
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	task automatic test_done;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer, waiting for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin bad_count++; test_done(); end
		err = pslverr;
		psel <= 0; penable <= 0;
		@(posedge pclk); // idle cycle keeps one assignment per time step
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(0, a, 32'h0);
	endtask
	task automatic wait_core(input logic lvl, input int lim);
		int n;
		for (n = 0; core_reset !== lvl && n < lim; n++) @(posedge pclk);
		if (core_reset !== lvl) begin bad_count++; test_done(); end
	endtask
	// read data checked against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			chk("prdata", exp_q.pop_front(), prdata);
	end
	initial begin
		seed = 32'hc1b1; presetn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; low_power_mode = 0; watchdog_cfg_fault = 0;
		pin_low = 0; sag = 0;
		repeat (16) @(posedge pclk);
		chk("port_preset", 1, port_preset);
		chk("pc_clear", 1, pc_clear);
		presetn <= 1;
		wait_core(0, 400);
		rd(`OFF_PIN_MODE, 32'h55);
		rd(`OFF_THRESHOLD, 32'h66);
		chk("port_preset", 0, port_preset);
		rd(`OFF_CONTROL, 32'h4);
		rd(`OFF_FILTER, 32'h1);
		apb(1, `OFF_FLAGS, 0);
		rd(`OFF_FLAGS, 0);
		apb(1, 12'h020, 0);
		chk("pslverr", 1, err);
		for (int i = 0; i < 6; i++) begin
			apb(1, `OFF_THRESHOLD, {24'h0, codes[i]});
			repeat (3) @(posedge pclk);
			chk("threshold_level", lvls[i], threshold_level);
		end
		apb(1, `OFF_PIN_MODE, 32'hAA);
		rd(`OFF_PIN_MODE, 32'hAA);
		chk("reset_pin_selected", 1, reset_pin_selected);
		pin_low <= 1;
		wait_core(1, 20);
		repeat (40) @(posedge pclk);
		pin_low <= 0;
		repeat (50) @(posedge pclk);
		chk("core_reset", 1, core_reset);
		wait_core(0, 400);
		rd(`OFF_PIN_MODE, 32'h55);
		do v = $random(seed); while (v[7:0] == 8'h55 || v[7:0] == 8'hAA);
		apb(1, `OFF_PIN_MODE, {24'h0, v[7:0]});
		repeat (10) @(posedge pclk);
		chk("core_reset", 0, core_reset);
		wait_core(1, 30);
		wait_core(0, 400);
		rd(`OFF_FLAGS, 32'h8);
		rd(`OFF_PIN_MODE, 32'h55);
		apb(1, `OFF_FLAGS, 0);
		rd(`OFF_FLAGS, 0);
		watchdog_cfg_fault <= 1;
		@(posedge pclk);
		watchdog_cfg_fault <= 0;
		rd(`OFF_FLAGS, 32'h1);
		apb(1, `OFF_FLAGS, 0);
		rd(`OFF_FLAGS, 0);
		repeat (100) @(posedge pclk);
		chk("core_reset", 0, core_reset);
		do v = $random(seed); while (v[7:0] inside {codes});
		apb(1, `OFF_THRESHOLD, {24'h0, v[7:0]});
		wait_core(1, 30);
		wait_core(0, 400);
		rd(`OFF_FLAGS, 32'h2);
		rd(`OFF_THRESHOLD, 32'h66);
		apb(1, `OFF_FLAGS, 0);
		apb(1, `OFF_FILTER, 0);
		apb(1, `OFF_THRESHOLD, 32'h33);
		sag <= 1;
		repeat (20) @(posedge pclk);
		sag <= 0;
		repeat (20) @(posedge pclk);
		chk("core_reset", 0, core_reset);
		low_power_mode <= 1;
		sag <= 1;
		repeat (200) @(posedge pclk);
		chk("core_reset", 0, core_reset);
		low_power_mode <= 0;
		wait_core(1, 60);
		sag <= 0;
		wait_core(0, 400);
		rd(`OFF_FLAGS, 32'h4);
		rd(`OFF_THRESHOLD, 32'h33);
		apb(1, `OFF_FLAGS, 0);
		rd(`OFF_FLAGS, 0);
		apb(1, `OFF_FILTER, 3);
		sag <= 1;
		repeat (400) @(posedge pclk);
		chk("core_reset", 0, core_reset);
		wait_core(1, 200);
		sag <= 0;
		wait_core(0, 400);
		rd(`OFF_FLAGS, 32'h4);
		repeat (3) @(posedge pclk);
		test_done();
	end
endmodule
bind mcu_reset_controller rstctl_sva u_sva (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_in,
	.supply_below_threshold, .slow_tick, .low_power_mode, .watchdog_cfg_fault,
	.core_reset, .pc_clear, .port_preset, .reset_pin_selected,
	.threshold_level);
